// [logic/bridge_chopper.sv]
// fixed-frequency current chopping for one bridge
// assumes sense_trip is the 195 mV comparator, synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module bridge_chopper (
  input wire logic clk,
  input wire logic reset,
  input wire logic pwm_start,
  input wire logic drive_active,
  input wire logic sense_trip,
  output logic chop
);
  logic [hbridge_pkg::count_width-1:0] blank_q, blank_d;
  logic chop_q, chop_d;
  logic active_q, active_d;

  always_comb begin
    blank_d = blank_q;
    chop_d = chop_q;
    active_d = drive_active;
    if (drive_active && !active_q) begin
      blank_d = hbridge_pkg::count_width'(hbridge_pkg::blank_cycles);
    end else if (blank_q != '0) begin
      blank_d = blank_q - 1'b1;
    end
    if (pwm_start) begin
      chop_d = 1'b0;
      blank_d = hbridge_pkg::count_width'(hbridge_pkg::blank_cycles);
    end else if (drive_active && blank_q == '0 && sense_trip) begin
      chop_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      blank_q <= '0;
      chop_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      blank_q <= blank_d;
      chop_q <= chop_d;
      active_q <= active_d;
    end
  end

  assign chop = chop_q;
endmodule : bridge_chopper
`default_nettype wire

// [logic/bridge_ocp.sv]
// over-current deglitch and retry for one bridge
// assumes limit flags come from per-switch analog current limits
`timescale 1ns/10ps
`default_nettype none
module bridge_ocp #(
  parameter int unsigned retry_cycles = hbridge_pkg::ocp_retry_cycles_default
) (
  input wire logic clk,
  input wire logic reset,
  input wire hbridge_pkg::limit_flags_type limits,
  output logic shut
);
  typedef enum logic [1:0] {ocp_run, ocp_off} ocp_state_type;
  ocp_state_type state_q, state_d;
  logic [hbridge_pkg::count_width-1:0] deg_q, deg_d;
  logic [hbridge_pkg::count_width-1:0] retry_q, retry_d;
  logic hit;

  assign hit = limits.hs_limit | limits.ls_limit;

  always_comb begin
    state_d = state_q;
    deg_d = deg_q;
    retry_d = retry_q;
    case (state_q)
      ocp_run: begin
        if (!hit) begin
          deg_d = '0;
        end else if (deg_q >= hbridge_pkg::count_width'(hbridge_pkg::ocp_deglitch_cycles)) begin
          state_d = ocp_off;
          retry_d = hbridge_pkg::count_width'(retry_cycles - 1);
          deg_d = '0;
        end else begin
          deg_d = deg_q + 1'b1;
        end
      end
      ocp_off: begin
        if (retry_q == '0) begin
          state_d = ocp_run;
        end else begin
          retry_d = retry_q - 1'b1;
        end
      end
      default: state_d = ocp_run;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ocp_run;
      deg_q <= '0;
      retry_q <= '0;
    end else begin
      state_q <= state_d;
      deg_q <= deg_d;
      retry_q <= retry_d;
    end
  end

  assign shut = (state_q == ocp_off);
endmodule : bridge_ocp
`default_nettype wire

// [logic/dual_hbridge_control_logic.sv]
// top of the dual h-bridge control logic: decode, chopping, sleep, faults
// assumes all pins and analog flags are synchronous to clk
// Behaviour
// - per bridge: 00 coast, 01 reverse, 10 forward, 11 brake.
// - fast decay floats all switches; slow decay shorts the winding low.
// - a chop trip cuts drive until the next pwm cycle starts.
// - sense is ignored for 4 us after drive turns on, except when it resumes after a thermal or over-current shutdown.
// - blanking is also the minimum on-time per pwm cycle.
// - trip comes from a 195 mV sense comparator.
// - on trip both low sides turn on until next pwm cycle.
// - chopping cycle timed by an internal 45 kHz pwm clock.
// - sleep low disables bridges, pump, resets logic, stops clocks.
// - inputs ignored while asleep, honoured again after wake.
// - bridges start up to 1.3 ms after sleep goes high.
// - over-current beyond deglitch disables that bridge and asserts fault.
// - after retry period re-enable and release fault; repeat if persistent.
// - over-current shuts only its own bridge.
// - high and low side over-current detected apart from sense path.
// - over-temperature disables switches, faults, resumes when cleared.
// - under-voltage disables all, resets logic, faults, resumes on recovery.
`timescale 1ns/10ps
`default_nettype none
module dual_hbridge_control_logic #(
  parameter int unsigned wake_cycles = hbridge_pkg::wake_cycles_default,
  parameter int unsigned ocp_retry_cycles = hbridge_pkg::ocp_retry_cycles_default
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sleep_n,
  input wire hbridge_pkg::ctrl_pair_type bridge_a_ctrl,
  input wire hbridge_pkg::ctrl_pair_type bridge_b_ctrl,
  input wire logic bridge_a_current_sense_in,
  input wire logic bridge_b_current_sense_in,
  input wire hbridge_pkg::limit_flags_type bridge_a_limits,
  input wire hbridge_pkg::limit_flags_type bridge_b_limits,
  input wire logic thermal_cutoff,
  input wire logic supply_low_lockout,
  output hbridge_pkg::drive_pair_type bridge_a_drive,
  output hbridge_pkg::drive_pair_type bridge_b_drive,
  output logic charge_pump_en,
  output logic fault_n_out,
  output logic fault_n_oe
);
  typedef enum logic [1:0] {st_sleep, st_wake, st_run} power_state_type;
  power_state_type pstate_q, pstate_d;
  logic [hbridge_pkg::count_width-1:0] wake_q, wake_d;
  logic [hbridge_pkg::count_width-1:0] pwm_q, pwm_d;
  logic core_reset;
  logic pwm_start;
  logic pump_q, pump_d;
  logic fault_q, fault_d;

  hbridge_pkg::ctrl_pair_type ctrl [2];
  hbridge_pkg::limit_flags_type lim [2];
  logic sense [2];
  logic chop [2];
  logic ocp_shut [2];
  hbridge_pkg::drive_pair_type drv_q [2];
  hbridge_pkg::drive_pair_type drv_d [2];

  assign ctrl[0] = bridge_a_ctrl;
  assign ctrl[1] = bridge_b_ctrl;
  assign lim[0] = bridge_a_limits;
  assign lim[1] = bridge_b_limits;
  assign sense[0] = bridge_a_current_sense_in;
  assign sense[1] = bridge_b_current_sense_in;

  // sleep and under-voltage both hold the internal logic in reset
  assign core_reset = reset | !sleep_n | supply_low_lockout;

  // power sequencing
  always_comb begin
    pstate_d = pstate_q;
    wake_d = wake_q;
    pump_d = 1'b0;
    case (pstate_q)
      st_sleep: begin
        pstate_d = st_wake;
        wake_d = hbridge_pkg::count_width'(wake_cycles - 1);
      end
      st_wake: begin
        pump_d = 1'b1;
        if (wake_q == '0) begin
          pstate_d = st_run;
        end else begin
          wake_d = wake_q - 1'b1;
        end
      end
      st_run: begin
        pump_d = 1'b1;
      end
      default: pstate_d = st_sleep;
    endcase
  end

  always_ff @(posedge clk) begin
    if (core_reset) begin
      pstate_q <= st_sleep;
      wake_q <= '0;
      pump_q <= 1'b0;
    end else begin
      pstate_q <= pstate_d;
      wake_q <= wake_d;
      pump_q <= pump_d;
    end
  end

  // internal pwm time base; held in reset while asleep
  always_comb begin
    if (pwm_q == hbridge_pkg::count_width'(hbridge_pkg::pwm_period_cycles - 1)) begin
      pwm_d = '0;
    end else begin
      pwm_d = pwm_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (core_reset) begin
      pwm_q <= '0;
    end else begin
      pwm_q <= pwm_d;
    end
  end

  assign pwm_start = (pwm_q == '0) && (pstate_q == st_run);

  // per bridge chopping, protection and output decode
  for (genvar b = 0; b < 2; b++) begin : g_bridge
    logic active;
    assign active = ctrl[b].in_1 ^ ctrl[b].in_2;

    bridge_chopper u_chop (
      .clk(clk),
      .reset(core_reset),
      .pwm_start(pwm_start),
      .drive_active(active && pstate_q == st_run),
      .sense_trip(sense[b]),
      .chop(chop[b])
    );

    bridge_ocp #(
      .retry_cycles(ocp_retry_cycles)
    ) u_ocp (
      .clk(clk),
      .reset(core_reset),
      .limits(lim[b]),
      .shut(ocp_shut[b])
    );

    always_comb begin
      drv_d[b] = hbridge_pkg::drive_coast;
      if (pstate_q != st_run || thermal_cutoff || ocp_shut[b]) begin
        drv_d[b] = hbridge_pkg::drive_coast;
      end else if (chop[b] && active) begin
        drv_d[b] = '{out_1: 1'b0, oe_1: 1'b1, out_2: 1'b0, oe_2: 1'b1};
      end else begin
        case ({ctrl[b].in_1, ctrl[b].in_2})
          2'b00: drv_d[b] = hbridge_pkg::drive_coast;
          2'b01: drv_d[b] = '{out_1: 1'b0, oe_1: 1'b1, out_2: 1'b1, oe_2: 1'b1};
          2'b10: drv_d[b] = '{out_1: 1'b1, oe_1: 1'b1, out_2: 1'b0, oe_2: 1'b1};
          2'b11: drv_d[b] = '{out_1: 1'b0, oe_1: 1'b1, out_2: 1'b0, oe_2: 1'b1};
          default: drv_d[b] = hbridge_pkg::drive_coast;
        endcase
      end
    end

    always_ff @(posedge clk) begin
      if (core_reset) begin
        drv_q[b] <= hbridge_pkg::drive_coast;
      end else begin
        drv_q[b] <= drv_d[b];
      end
    end
  end

  // fault is the or of every source; under-voltage bypasses the core reset
  always_comb begin
    fault_d = supply_low_lockout | thermal_cutoff | ocp_shut[0] | ocp_shut[1];
  end

  always_ff @(posedge clk) begin
    if (reset || !sleep_n) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
    end
  end

  assign bridge_a_drive = drv_q[0];
  assign bridge_b_drive = drv_q[1];
  assign charge_pump_en = pump_q;
  assign fault_n_out = 1'b0;
  assign fault_n_oe = fault_q;
endmodule : dual_hbridge_control_logic
`default_nettype wire

// [shared/hbridge_pkg.sv]
// shared constants and carrier types for the dual h-bridge control logic
// assumes a 200 MHz clock; analog comparators arrive as synchronous levels
package hbridge_pkg;
  localparam int unsigned clk_mhz = 200;
  localparam int unsigned pwm_freq_hz = 45000;
  localparam int unsigned pwm_period_cycles = (clk_mhz * 1000000) / pwm_freq_hz;
  localparam int unsigned blank_time_ns = 4000;
  localparam int unsigned blank_cycles = (blank_time_ns * clk_mhz + 999) / 1000;
  localparam int unsigned ocp_deglitch_ns = 4700;
  localparam int unsigned ocp_deglitch_cycles = (ocp_deglitch_ns * clk_mhz + 999) / 1000;
  localparam int unsigned ocp_retry_us = 1400;
  localparam int unsigned ocp_retry_cycles_default = ocp_retry_us * clk_mhz;
  localparam int unsigned wake_time_us = 1300;
  localparam int unsigned wake_cycles_default = wake_time_us * clk_mhz;
  localparam int unsigned trip_ref_mv = 195;
  localparam int unsigned count_width = 20;

  // one bridge's pair of control inputs
  typedef struct packed {
    logic in_1;
    logic in_2;
  } ctrl_pair_type;

  // one bridge's output pins: level and enable (enable high while driven)
  typedef struct packed {
    logic out_1;
    logic oe_1;
    logic out_2;
    logic oe_2;
  } drive_pair_type;

  // analog limit flags of one bridge
  typedef struct packed {
    logic hs_limit;
    logic ls_limit;
  } limit_flags_type;

  localparam drive_pair_type drive_coast = 4'h0;
endpackage : hbridge_pkg

// [test/ctrl_pwm_source.sv]
// partner model: controller driving one bridge's control pair with pwm
// assumes the bench picks fast or slow decay and clocks it from clk
`timescale 1ns/10ps
`default_nettype none
module ctrl_pwm_source (
  input wire logic clk,
  input wire logic run,
  input wire logic slow,
  output hbridge_pkg::ctrl_pair_type ctrl
);
  logic [2:0] phase;
  initial begin
    phase = 3'h0;
    ctrl = 2'b00;
  end
  always @(negedge clk) begin
    phase <= phase + 3'h1;
    if (!run) ctrl <= 2'b00;
    else if (slow) ctrl <= {1'b1, phase[2]};
    else ctrl <= {phase[2], 1'b0};
  end
endmodule : ctrl_pwm_source
`default_nettype wire

// [test/dual_hbridge_control_logic_assertions.sv]
// port checker for the dual h-bridge control logic
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module dual_hbridge_control_logic_assertions #(
  parameter int unsigned wake_cycles = 10,
  parameter int unsigned ocp_retry_cycles = 20
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sleep_n,
  input wire hbridge_pkg::ctrl_pair_type bridge_a_ctrl,
  input wire hbridge_pkg::ctrl_pair_type bridge_b_ctrl,
  input wire hbridge_pkg::limit_flags_type bridge_a_limits,
  input wire logic thermal_cutoff,
  input wire logic supply_low_lockout,
  input wire hbridge_pkg::drive_pair_type bridge_a_drive,
  input wire hbridge_pkg::drive_pair_type bridge_b_drive,
  input wire logic charge_pump_en,
  input wire logic fault_n_out,
  input wire logic fault_n_oe
);
  localparam int unsigned deg = hbridge_pkg::ocp_deglitch_cycles;
  logic core_rst;
  logic [19:0] awake_q, awake_d, lim_q, lim_d;
  assign core_rst = reset || !sleep_n || supply_low_lockout;
  always_comb begin
    awake_d = core_rst ? 20'h0 : awake_q + 20'h1;
    lim_d = (core_rst || bridge_a_limits == 2'b00) ? 20'h0 : lim_q + 20'h1;
  end
  always_ff @(posedge clk) begin
    awake_q <= awake_d;
    lim_q <= lim_d;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_ocp_held;
    lim_q >= deg + 5 && lim_q <= deg + ocp_retry_cycles;
  endsequence
  sequence s_all_coast;
    bridge_a_drive == hbridge_pkg::drive_coast && bridge_b_drive == hbridge_pkg::drive_coast;
  endsequence
  a_fault_open_drain: assert property (fault_n_out == 1'b0)
    else $error("fault pin level not low");
  a_forward_cause: assert property (bridge_a_drive.out_1 |-> $past(bridge_a_ctrl) == 2'b10)
    else $error("bridge a driven forward without forward code");
  a_reverse_cause: assert property (bridge_b_drive.out_2 |-> $past(bridge_b_ctrl) == 2'b01)
    else $error("bridge b driven reverse without reverse code");
  a_coast_float: assert property (bridge_b_ctrl == 2'b00 |=> bridge_b_drive == 4'h0)
    else $error("bridge b not floating on coast code");
  a_sleep_off: assert property (!sleep_n && !supply_low_lockout |=> s_all_coast ##0 !charge_pump_en && !fault_n_oe)
    else $error("sleep did not shut outputs");
  a_wake_wait: assert property (bridge_a_drive.oe_1 || bridge_b_drive.oe_1 |-> awake_q >= wake_cycles)
    else $error("bridge driven before wake time");
  a_pump_awake: assert property (awake_q >= 3 |-> charge_pump_en)
    else $error("charge pump off while awake");
  a_lockout_fault: assert property (supply_low_lockout [*2] |=> s_all_coast ##0 fault_n_oe)
    else $error("lockout did not fault and coast");
  a_thermal_off: assert property ((thermal_cutoff && sleep_n && !supply_low_lockout) [*2] |=> s_all_coast ##0 fault_n_oe)
    else $error("thermal cutoff did not fault and coast");
  a_ocp_shut: assert property (s_ocp_held |-> bridge_a_drive == 4'h0 && fault_n_oe)
    else $error("held limit did not shut bridge a");
endmodule : dual_hbridge_control_logic_assertions
bind dual_hbridge_control_logic dual_hbridge_control_logic_assertions #(
  .wake_cycles(wake_cycles), .ocp_retry_cycles(ocp_retry_cycles)) checker_inst (.clk, .reset,
  .sleep_n, .bridge_a_ctrl, .bridge_b_ctrl, .bridge_a_limits, .thermal_cutoff, .supply_low_lockout,
  .bridge_a_drive, .bridge_b_drive, .charge_pump_en, .fault_n_out, .fault_n_oe);
`default_nettype wire

// [test/dual_hbridge_control_logic_bench.sv]
// self-checking bench for the dual h-bridge control logic
// assumes the package and the pwm source model are compiled first
`timescale 1ns/10ps
`default_nettype none
module dual_hbridge_control_logic_bench;
  localparam int wake_n = 10;
  localparam int retry_n = 20;
  logic clk, reset, sleep_n, thermal_cutoff, supply_low_lockout, pwm_run, pwm_slow;
  logic bridge_a_current_sense_in, bridge_b_current_sense_in, charge_pump_en, fault_n_out, fault_n_oe;
  hbridge_pkg::ctrl_pair_type bridge_a_ctrl, b_ctrl;
  hbridge_pkg::limit_flags_type bridge_a_limits, bridge_b_limits;
  hbridge_pkg::ctrl_pair_type src_ctrl, bridge_b_ctrl;
  hbridge_pkg::drive_pair_type bridge_a_drive, bridge_b_drive;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  assign bridge_b_ctrl = pwm_run ? src_ctrl : b_ctrl;
  dual_hbridge_control_logic #(.wake_cycles(wake_n), .ocp_retry_cycles(retry_n))
    dual_hbridge_control_logic_inst (.clk, .reset, .sleep_n, .bridge_a_ctrl, .bridge_b_ctrl,
    .bridge_a_current_sense_in, .bridge_b_current_sense_in, .bridge_a_limits, .bridge_b_limits,
    .thermal_cutoff, .supply_low_lockout, .bridge_a_drive, .bridge_b_drive, .charge_pump_en,
    .fault_n_out, .fault_n_oe);
  ctrl_pwm_source ctrl_pwm_source_inst (.clk, .run(pwm_run), .slow(pwm_slow), .ctrl(src_ctrl));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      give_verdict();
    end
  end
  function automatic logic [3:0] exp_drive(input logic [1:0] c);
    case (c)
      2'b01: exp_drive = 4'h7;
      2'b10: exp_drive = 4'hD;
      2'b11: exp_drive = 4'h5;
      default: exp_drive = 4'h0;
    endcase
  endfunction : exp_drive
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic span(input logic [3:0] v, output int n);
    n = 0;
    while (bridge_a_drive === v && n < 6000) begin
      tick(1);
      n++;
    end
  endtask : span
  task automatic t_decode;
    for (int i = 0; i < 4; i++) begin
      bridge_a_ctrl = 2'(i);
      b_ctrl = 2'(3 - i);
      tick(1);
      check(bridge_a_drive, exp_drive(2'(i)));
      check(bridge_b_drive, exp_drive(2'(3 - i)));
    end
    check({3'h0, charge_pump_en}, 4'h1);
  endtask : t_decode
  task automatic t_sleep;
    sleep_n = 1'b0;
    tick(2);
    bridge_a_ctrl = 2'b01;
    tick(2);
    check(bridge_a_drive, 4'h0);
    check({3'h0, charge_pump_en}, 4'h0);
    sleep_n = 1'b1;
    tick(wake_n - 2);
    check(bridge_a_drive, 4'h0);
    tick(8);
    check(bridge_a_drive, 4'h7);
  endtask : t_sleep
  task automatic t_chop;
    int m, n;
    bridge_a_ctrl = 2'b10;
    bridge_a_current_sense_in = 1'b1;
    tick(3);
    // pass the on phase still running from wake, then the off phase to the next pwm start
    span(4'hD, n);
    span(4'h5, n);
    span(4'hD, m);
    check(bridge_a_drive, 4'h5);
    bridge_a_current_sense_in = 1'b0;
    check({3'h0, m >= hbridge_pkg::blank_cycles && m <= hbridge_pkg::blank_cycles + 4}, 4'h1);
    span(4'h5, n);
    check({3'h0, m + n + 3 >= hbridge_pkg::pwm_period_cycles && m + n <= hbridge_pkg::pwm_period_cycles + 3}, 4'h1);
    check(bridge_a_drive, 4'hD);
  endtask : t_chop
  task automatic t_ocp(input bit on_b);
    bridge_a_ctrl = 2'b10;
    b_ctrl = 2'b01;
    if (on_b) bridge_b_limits = 2'b01;
    else bridge_a_limits = 2'b10;
    tick(hbridge_pkg::ocp_deglitch_cycles + 6);
    check(on_b ? bridge_b_drive : bridge_a_drive, 4'h0);
    check(on_b ? bridge_a_drive : bridge_b_drive, on_b ? 4'hD : 4'h7);
    check({3'h0, fault_n_oe}, 4'h1);
    check({3'h0, fault_n_out}, 4'h0);
    bridge_a_limits = 2'b00;
    bridge_b_limits = 2'b00;
    tick(retry_n + 6);
    check({bridge_a_drive[3:2], bridge_b_drive[1:0]}, 4'hF);
    check({3'h0, fault_n_oe}, 4'h0);
  endtask : t_ocp
  task automatic t_faults;
    thermal_cutoff = 1'b1;
    tick(3);
    check(bridge_a_drive | bridge_b_drive, 4'h0);
    check({3'h0, fault_n_oe}, 4'h1);
    thermal_cutoff = 1'b0;
    tick(3);
    check(bridge_a_drive, 4'hD);
    supply_low_lockout = 1'b1;
    tick(3);
    check(bridge_a_drive, 4'h0);
    check({charge_pump_en, fault_n_oe, 2'h0}, 4'h4);
    supply_low_lockout = 1'b0;
    tick(wake_n + 6);
    check({fault_n_oe, bridge_a_drive[3:1]}, 4'h6);
  endtask : t_faults
  task automatic t_pwm(input logic slow);
    logic [1:0] c;
    pwm_slow = slow;
    pwm_run = 1'b1;
    repeat (24) begin
      // take the control pair as the design samples it
      @(posedge clk);
      c = bridge_b_ctrl;
      tick(1);
      check(bridge_b_drive, exp_drive(c));
    end
    pwm_run = 1'b0;
    tick(1);
  endtask : t_pwm
  task automatic give_verdict;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    {reset, sleep_n, thermal_cutoff, supply_low_lockout, pwm_run, pwm_slow} = 6'b110000;
    {bridge_a_current_sense_in, bridge_b_current_sense_in} = 2'b00;
    {bridge_a_ctrl, b_ctrl, bridge_a_limits, bridge_b_limits} = 8'h00;
    tick(3);
    reset = 1'b0;
    tick(wake_n + 6);
    t_decode();
    t_sleep();
    t_chop();
    t_ocp(1'b0);
    t_ocp(1'b1);
    t_faults();
    t_pwm(1'b0);
    t_pwm(1'b1);
    give_verdict();
  end
endmodule : dual_hbridge_control_logic_bench
`default_nettype wire
